// File: ptm_defines.svh
// register offsets, field positions, reset values and bus codes of the periodic timer
// assumes a 32-bit AXI4-Lite bus with one 8-bit register per aligned word
`ifndef PTM_DEFINES_SVH
`define PTM_DEFINES_SVH

`define PTM_ADDR_W 6
`define PTM_OFF_CTRL0 6'h00
`define PTM_OFF_CTRL1 6'h04
`define PTM_OFF_CNT_LO 6'h08
`define PTM_OFF_CNT_HI 6'h0c
`define PTM_OFF_DUTY_LO 6'h10
`define PTM_OFF_DUTY_HI 6'h14
`define PTM_OFF_PER_LO 6'h18
`define PTM_OFF_PER_HI 6'h1c
`define PTM_OFF_FLAGS 6'h20

`define PTM_C0_PAUSE 7
`define PTM_C0_ENABLE 3
`define PTM_C1_MODE_HI 7
`define PTM_C1_MODE_LO 6
`define PTM_C1_ACT_HI 5
`define PTM_C1_ACT_LO 4
`define PTM_C1_INIT 3
`define PTM_C1_INV 2
`define PTM_C1_CLRSEL 0
`define PTM_FLAG_CMP 0
`define PTM_FLAG_PER 1

`define PTM_RST_BYTE 8'h00
`define PTM_RST_VAL10 10'h000
`define PTM_ACT_HOLD 2'h0
`define PTM_ACT_LOW 2'h1
`define PTM_ACT_HIGH 2'h2
`define PTM_ACT_TOGGLE 2'h3
`define PTM_RESP_OKAY 2'h0
`define PTM_RESP_SLVERR 2'h2

`endif

// File: ptm_pkg.sv
// types of the periodic timer: bus carriers and operating modes
// assumes ptm_defines.svh for widths
`include "ptm_defines.svh"

package ptm_pkg;

   // listed in the order of the two-bit mode field
   typedef enum logic [1:0] {
      MODE_COMPARE,
      MODE_CAPTURE,
      MODE_PWM,
      MODE_TIMER
   } ptm_mode_t;

   typedef struct packed {
      logic awvalid;
      logic [`PTM_ADDR_W-1:0] awaddr;
      logic wvalid;
      logic [31:0] wdata;
      logic [3:0] wstrb;
      logic bready;
      logic arvalid;
      logic [`PTM_ADDR_W-1:0] araddr;
      logic rready;
   } ptm_axi_req_t;

   typedef struct packed {
      logic awready;
      logic wready;
      logic bvalid;
      logic [1:0] bresp;
      logic arready;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
   } ptm_axi_rsp_t;

endpackage

// File: ptm_tb_top.sv
// self-checking testbench of the periodic timer: register map, compare, timer and pwm modes
// assumes ptm_top, ptm_pkg and ptm_defines.svh on the compile path; 10 MHz clock
`timescale 1ns/1ps
`include "ptm_defines.svh"

module ptm_tb_top;
   import ptm_pkg::*;

   logic clk_i;
   logic rst_n_i;
   ptm_axi_req_t req;
   ptm_axi_rsp_t rsp;
   logic pin;
   logic pin_en;
   logic cmp_req;
   logic per_req;
   int n_fail;
   int samples_checked;
   int seed;
   logic [31:0] rd;
   logic [1:0] resp;
   int k;
   int d;
   int p;
   int n;
   int act;
   int shadow[$];
   logic lvl;

   ptm_top u_ptm_top (
      .clk_i(clk_i),
      .rst_n_i(rst_n_i),
      .axi_req_i(req),
      .axi_rsp_o(rsp),
      .timer_out_o(pin),
      .timer_out_en_o(pin_en),
      .compare_req_o(cmp_req),
      .period_req_o(per_req)
   );

   initial begin
      clk_i = 1'b0;
      forever #50 clk_i = ~clk_i;
   end

   ////////////////////////////////////////////////////////////////////////////////
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      samples_checked++;
      if (got !== exp) begin
         n_fail++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask

   // bready and rready stay high for the whole run, so no task ever lowers them
   task automatic wr(input logic [5:0] a, input logic [7:0] v);
      req.awvalid <= 1'b1;
      req.awaddr <= a;
      req.wvalid <= 1'b1;
      req.wdata <= {24'h000000, v};
      req.wstrb <= 4'hf;
      while (1'b1) begin
         @(posedge clk_i);
         if (req.awvalid && rsp.awready)
            req.awvalid <= 1'b0;
         if (req.wvalid && rsp.wready)
            req.wvalid <= 1'b0;
         if (rsp.bvalid === 1'b1) begin
            resp = rsp.bresp;
            break;
         end
      end
   endtask

   task automatic rdr(input logic [5:0] a);
      req.arvalid <= 1'b1;
      req.araddr <= a;
      while (1'b1) begin
         @(posedge clk_i);
         if (req.arvalid && rsp.arready)
            req.arvalid <= 1'b0;
         if (rsp.rvalid === 1'b1) begin
            rd = rsp.rdata;
            resp = rsp.rresp;
            break;
         end
      end
   endtask

   function automatic logic [7:0] ctl(logic [1:0] m, logic [1:0] a, logic i, logic v, logic c);
      return {m, a, i, v, 1'b0, c};
   endfunction

   // the timer is switched off before mode or value changes, then flags are cleared
   task automatic cfg(input logic [7:0] c1, input int dv, input int pv);
      logic [9:0] dd;
      logic [9:0] pp;
      dd = dv[9:0];
      pp = pv[9:0];
      wr(`PTM_OFF_CTRL0, 8'h00);
      wr(`PTM_OFF_CTRL1, c1);
      wr(`PTM_OFF_DUTY_LO, dd[7:0]);
      wr(`PTM_OFF_DUTY_HI, {6'h00, dd[9:8]});
      wr(`PTM_OFF_PER_LO, pp[7:0]);
      wr(`PTM_OFF_PER_HI, {6'h00, pp[9:8]});
      wr(`PTM_OFF_FLAGS, 8'h03);
      wr(`PTM_OFF_CTRL0, 8'h08);
   endtask

   // bench model of one pwm setting: active cycles over two whole periods
   function automatic int pwm_active_model(input int a, input int dv, input int nv);
      if (a == `PTM_ACT_LOW)
         return 2 * nv;
      if (a == `PTM_ACT_HOLD)
         return 0;
      return 2 * ((dv < nv) ? dv : nv);
   endfunction

   task automatic flags(input string what, input logic [31:0] exp);
      wr(`PTM_OFF_CTRL0, 8'h00);
      rdr(`PTM_OFF_FLAGS);
      chk(what, exp, rd);
   endtask

   task automatic meas(input logic l, input int cnt);
      k = 0;
      repeat (cnt) begin
         @(posedge clk_i);
         if (pin === l)
            k++;
      end
   endtask

   // edges between two pin changes; phase of the start does not matter
   task automatic gap;
      logic p0;
      p0 = pin;
      k = 0;
      while (pin === p0 && k < 3000) begin
         @(posedge clk_i);
         k++;
      end
      p0 = pin;
      k = 0;
      while (pin === p0 && k < 3000) begin
         @(posedge clk_i);
         k++;
      end
   endtask

   task automatic wrap_up;
      $display("checks %0d mismatches %0d", samples_checked, n_fail);
      if (n_fail == 0 && samples_checked > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      req = '0;
      req.bready = 1'b1;
      req.rready = 1'b1;
      rst_n_i = 1'b0;
      seed = 32'h31f1fcf0;
      n_fail = 0;
      samples_checked = 0;
      repeat (12) @(posedge clk_i);
      rst_n_i <= 1'b1;
      @(posedge clk_i);
      for (int i = 0; i <= 8; i++) begin
         rdr(6'(4 * i));
         chk("reset value", 32'h0, rd);
         chk("read response", `PTM_RESP_OKAY, resp);
      end
      rdr(6'h24);
      chk("unmapped read response", `PTM_RESP_SLVERR, resp);
      wr(6'h3c, 8'hff);
      chk("unmapped write response", `PTM_RESP_SLVERR, resp);
      wr(`PTM_OFF_CNT_LO, 8'hff);
      rdr(`PTM_OFF_CNT_LO);
      chk("counter low read only", 32'h0, rd);
      $display("test reset and map done");
      for (int i = 4; i <= 7; i++) begin
         k = $random(seed);
         wr(6'(4 * i), k[7:0]);
         shadow.push_back((i % 2) ? (k & 3) : (k & 255));
         rdr(6'(4 * i));
         chk("rw register", shadow.pop_front(), rd);
      end
      $display("test value registers done");
      p = 20 + ($random(seed) & 15);
      d = 5 + ($random(seed) & 7);
      cfg(ctl(2'h0, `PTM_ACT_TOGGLE, 1'b0, 1'b0, 1'b0), d, p);
      gap;
      chk("toggle gap period clear", p, k);
      chk("pin enable compare", 32'h1, {31'h0, pin_en});
      chk("compare request", 32'h1, {31'h0, cmp_req});
      flags("flags period clear", 32'h3);
      wr(`PTM_OFF_FLAGS, 8'h03);
      rdr(`PTM_OFF_FLAGS);
      chk("flags cleared", 32'h0, rd);
      cfg(ctl(2'h0, `PTM_ACT_TOGGLE, 1'b0, 1'b0, 1'b1), p, d);
      gap;
      chk("toggle gap duty clear", p, k);
      flags("flags duty clear", 32'h1);
      for (int a = 0; a < 3; a++) begin
         lvl = (a != 2) ^ (a == 0);
         cfg(ctl(2'h0, 2'(a), a != 2, a == 0, 1'b0), d, p);
         repeat (3) @(posedge clk_i);
         chk("initial pin level", {31'h0, lvl}, {31'h0, pin});
         repeat (2 * p) @(posedge clk_i);
         meas(a == 2, p);
         chk("pin after duty match", p, k);
      end
      $display("test compare mode done");
      cfg(ctl(2'h3, `PTM_ACT_TOGGLE, 1'b1, 1'b0, 1'b0), d, p);
      repeat (2 * p) @(posedge clk_i);
      chk("pin enable timer", 32'h0, {31'h0, pin_en});
      flags("flags timer mode", 32'h3);
      cfg(ctl(2'h1, `PTM_ACT_HOLD, 1'b0, 1'b0, 1'b0), d, p);
      repeat (2 * p) @(posedge clk_i);
      chk("pin enable capture", 32'h0, {31'h0, pin_en});
      flags("flags capture mode", 32'h3);
      $display("test timer mode done");
      for (int c = 0; c < 6; c++) begin
         p = (c == 5) ? 0 : 8 + ($random(seed) & 31);
         d = (c == 4) ? p + 3 : (c == 5) ? 10 : (($random(seed) & 255) % (p - 1)) + 1;
         lvl = c[0] ^ c[1];
         n = (p == 0) ? 1024 : p;
         act = (c == 2) ? `PTM_ACT_LOW : (c == 3) ? `PTM_ACT_HOLD : `PTM_ACT_HIGH;
         cfg(ctl(2'h2, act[1:0], c[0], c[1], c[2]), d, p);
         repeat (4) @(posedge clk_i);
         meas(lvl, 2 * n);
         chk("pwm active cycles", pwm_active_model(act, d, n), k);
         flags("pwm flags", (d < n) ? 32'h3 : 32'h2);
      end
      $display("test pwm mode done");
      cfg(ctl(2'h3, `PTM_ACT_HOLD, 1'b0, 1'b0, 1'b0), 5, 0);
      repeat (50) @(posedge clk_i);
      wr(`PTM_OFF_CTRL0, 8'h88);
      rdr(`PTM_OFF_CNT_LO);
      k = rd;
      repeat (20) @(posedge clk_i);
      rdr(`PTM_OFF_CNT_LO);
      chk("paused counter", k, rd);
      wr(`PTM_OFF_CTRL0, 8'h08);
      repeat (10) @(posedge clk_i);
      rdr(`PTM_OFF_CNT_LO);
      chk("resumed counter ahead", 32'h1, {31'h0, rd > k});
      wr(`PTM_OFF_CTRL0, 8'h00);
      rdr(`PTM_OFF_CNT_LO);
      k = rd;
      repeat (20) @(posedge clk_i);
      rdr(`PTM_OFF_CNT_LO);
      chk("stopped counter", k, rd);
      wr(`PTM_OFF_CTRL0, 8'h08);
      rdr(`PTM_OFF_CNT_LO);
      chk("restarted counter low", 32'h1, {31'h0, rd < 8});
      rdr(`PTM_OFF_CNT_HI);
      chk("counter high bits", 32'h0, rd);
      $display("test pause and enable done");
      wrap_up;
   end

   // whole run is under 4k cycles; this limit of 40k cycles leaves ample margin
   initial begin
      #4000000;
      n_fail++;
      $display("ERROR watchdog expected end seen timeout");
      wrap_up;
   end
endmodule

// File: ptm_top.sv
// periodic timer with 10-bit counter, duty and period comparators and one output pin
// assumes an AXI4-Lite master on clk_i; the counter advances once per clk_i rising edge
//
// How it works
// - counter readable as low byte and two-bit high byte, read only.
// - duty value in low byte plus two high bits, cleared at reset.
// - period value in low byte plus two high bits, cleared at reset.
// - upper six bits of every high-byte register read zero.
// - two-bit mode field picks compare, pwm or timer; capture value counts like pwm, pin undriven.
// - compare mode, clear-select low: period match or overflow clears; both flags.
// - clear-select high: duty match clears, only compare flag raised.
// - compare mode pin changes only on duty match or enable rise, not period match.
// - duty match drives pin high, low, toggles, or leaves it by action field.
// - enable rising edge loads pin with selected initial level.
// - timer mode counts and flags like compare mode but leaves pin undriven.
// - pwm ignores clear-select; period match clears, duty sets duty cycle.
// - pwm raises compare flag on duty match, period flag on period match.
// - pwm: initial-level bit picks active level, action enables or forces, invert.
// - period 1..1023 gives that many counts, zero gives 1024 counts.
// - duty at or above a nonzero period keeps pwm permanently active.
// - pwm counting and matching continue while action forces a level.
// - enable rising clears the counter; enable low freezes it.
// - pause holds the counter; releasing pause resumes from held value.
// - invert bit inverts the level presented on the output pin.
`timescale 1ns/1ps
`include "ptm_defines.svh"

module ptm_top (
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire ptm_pkg::ptm_axi_req_t axi_req_i,
   output ptm_pkg::ptm_axi_rsp_t axi_rsp_o,
   output logic timer_out_o,
   output logic timer_out_en_o,
   output logic compare_req_o,
   output logic period_req_o
);
   import ptm_pkg::*;

   function automatic logic [7:0] high_bits(input logic [9:0] v);
      high_bits = {6'h00, v[9:8]};
   endfunction

   ////////////////////////////////////////////////////////////////////////////////////////////
   // register state

   logic counter_enable_q;
   logic counter_pause_q;
   logic [1:0] mode_q;
   logic [1:0] action_q;
   logic init_level_q;
   logic invert_q;
   logic clear_select_q;
   logic [9:0] duty_q;
   logic [9:0] period_q;
   logic [9:0] cnt_q;
   logic cmp_flag_q;
   logic per_flag_q;
   logic enable_prev_q;
   logic pin_q;
   ptm_mode_t mode;

   assign mode = ptm_mode_t'(mode_q);

   ////////////////////////////////////////////////////////////////////////////////////////////
   // axi4-lite slave

   logic aw_full_q;
   logic w_full_q;
   logic [`PTM_ADDR_W-1:0] awaddr_q;
   logic [31:0] wdata_q;
   logic [3:0] wstrb_q;
   logic bvalid_q;
   logic [1:0] bresp_q;
   logic rvalid_q;
   logic [31:0] rdata_q;
   logic [1:0] rresp_q;
   logic do_write;
   logic ar_take;
   logic byte_we;
   logic wr_ctrl0;
   logic wr_ctrl1;
   logic wr_duty_lo;
   logic wr_duty_hi;
   logic wr_per_lo;
   logic wr_per_hi;
   logic wr_flags;
   logic [7:0] rd_byte;
   logic rd_ok;
   logic wr_ok;

   assign do_write = aw_full_q && w_full_q && !bvalid_q;
   assign ar_take = axi_req_i.arvalid && !rvalid_q;
   // 8-bit registers live in lane 0; a write without lane 0 stores nothing
   assign byte_we = do_write && wstrb_q[0];
   assign wr_ctrl0 = byte_we && awaddr_q == `PTM_OFF_CTRL0;
   assign wr_ctrl1 = byte_we && awaddr_q == `PTM_OFF_CTRL1;
   assign wr_duty_lo = byte_we && awaddr_q == `PTM_OFF_DUTY_LO;
   assign wr_duty_hi = byte_we && awaddr_q == `PTM_OFF_DUTY_HI;
   assign wr_per_lo = byte_we && awaddr_q == `PTM_OFF_PER_LO;
   assign wr_per_hi = byte_we && awaddr_q == `PTM_OFF_PER_HI;
   assign wr_flags = byte_we && awaddr_q == `PTM_OFF_FLAGS;

   always_comb begin
      wr_ok = 1'b1;
      case (awaddr_q)
         `PTM_OFF_CTRL0, `PTM_OFF_CTRL1, `PTM_OFF_CNT_LO, `PTM_OFF_CNT_HI,
         `PTM_OFF_DUTY_LO, `PTM_OFF_DUTY_HI, `PTM_OFF_PER_LO, `PTM_OFF_PER_HI,
         `PTM_OFF_FLAGS: wr_ok = 1'b1;
         default: wr_ok = 1'b0;
      endcase
   end

   always_comb begin
      rd_byte = `PTM_RST_BYTE;
      rd_ok = 1'b1;
      case (axi_req_i.araddr)
         `PTM_OFF_CTRL0: rd_byte = {counter_pause_q, 3'h0, counter_enable_q, 3'h0};
         `PTM_OFF_CTRL1: rd_byte = {mode_q, action_q, init_level_q, invert_q, 1'b0,
                                    clear_select_q};
         `PTM_OFF_CNT_LO: rd_byte = cnt_q[7:0];
         `PTM_OFF_CNT_HI: rd_byte = high_bits(cnt_q);
         `PTM_OFF_DUTY_LO: rd_byte = duty_q[7:0];
         `PTM_OFF_DUTY_HI: rd_byte = high_bits(duty_q);
         `PTM_OFF_PER_LO: rd_byte = period_q[7:0];
         `PTM_OFF_PER_HI: rd_byte = high_bits(period_q);
         `PTM_OFF_FLAGS: rd_byte = {6'h00, per_flag_q, cmp_flag_q};
         default: rd_ok = 1'b0;
      endcase
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         aw_full_q <= 1'b0;
         awaddr_q <= '0;
      end else if (do_write) begin
         aw_full_q <= 1'b0;
      end else if (axi_req_i.awvalid && !aw_full_q) begin
         aw_full_q <= 1'b1;
         awaddr_q <= {axi_req_i.awaddr[`PTM_ADDR_W-1:2], 2'b00};
      end
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         w_full_q <= 1'b0;
         wdata_q <= '0;
         wstrb_q <= '0;
      end else if (do_write) begin
         w_full_q <= 1'b0;
      end else if (axi_req_i.wvalid && !w_full_q) begin
         w_full_q <= 1'b1;
         wdata_q <= axi_req_i.wdata;
         wstrb_q <= axi_req_i.wstrb;
      end
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         bvalid_q <= 1'b0;
         bresp_q <= `PTM_RESP_OKAY;
      end else if (do_write) begin
         bvalid_q <= 1'b1;
         bresp_q <= wr_ok ? `PTM_RESP_OKAY : `PTM_RESP_SLVERR;
      end else if (axi_req_i.bready) begin
         bvalid_q <= 1'b0;
      end
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rvalid_q <= 1'b0;
         rdata_q <= '0;
         rresp_q <= `PTM_RESP_OKAY;
      end else if (ar_take) begin
         rvalid_q <= 1'b1;
         rdata_q <= {24'h000000, rd_byte};
         rresp_q <= rd_ok ? `PTM_RESP_OKAY : `PTM_RESP_SLVERR;
      end else if (axi_req_i.rready) begin
         rvalid_q <= 1'b0;
      end
   end

   always_comb begin
      axi_rsp_o.awready = !aw_full_q;
      axi_rsp_o.wready = !w_full_q;
      axi_rsp_o.bvalid = bvalid_q;
      axi_rsp_o.bresp = bresp_q;
      axi_rsp_o.arready = !rvalid_q;
      axi_rsp_o.rvalid = rvalid_q;
      axi_rsp_o.rdata = rdata_q;
      axi_rsp_o.rresp = rresp_q;
   end

   ////////////////////////////////////////////////////////////////////////////////////////////
   // control and value registers

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         counter_enable_q <= 1'b0;
         counter_pause_q <= 1'b0;
      end else if (wr_ctrl0) begin
         counter_enable_q <= wdata_q[`PTM_C0_ENABLE];
         counter_pause_q <= wdata_q[`PTM_C0_PAUSE];
      end
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         mode_q <= 2'h0;
         action_q <= `PTM_ACT_HOLD;
         init_level_q <= 1'b0;
         invert_q <= 1'b0;
         clear_select_q <= 1'b0;
      end else if (wr_ctrl1) begin
         mode_q <= wdata_q[`PTM_C1_MODE_HI:`PTM_C1_MODE_LO];
         action_q <= wdata_q[`PTM_C1_ACT_HI:`PTM_C1_ACT_LO];
         init_level_q <= wdata_q[`PTM_C1_INIT];
         invert_q <= wdata_q[`PTM_C1_INV];
         clear_select_q <= wdata_q[`PTM_C1_CLRSEL];
      end
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         duty_q <= `PTM_RST_VAL10;
      end else if (wr_duty_lo) begin
         duty_q[7:0] <= wdata_q[7:0];
      end else if (wr_duty_hi) begin
         duty_q[9:8] <= wdata_q[1:0];
      end
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         period_q <= `PTM_RST_VAL10;
      end else if (wr_per_lo) begin
         period_q[7:0] <= wdata_q[7:0];
      end else if (wr_per_hi) begin
         period_q[9:8] <= wdata_q[1:0];
      end
   end

   ////////////////////////////////////////////////////////////////////////////////////////////
   // counter and comparators

   logic enable_rise;
   logic run;
   logic [10:0] cnt_inc;
   logic match_a;
   logic match_p;
   logic clear_cnt;
   logic raise_cmp;
   logic raise_per;

   assign enable_rise = counter_enable_q && !enable_prev_q;
   assign run = counter_enable_q && !counter_pause_q && !enable_rise;
   assign cnt_inc = {1'b0, cnt_q} + 11'h001;
   // period zero matches on the wrap to zero, giving 1024 counts
   assign match_a = run && cnt_inc[9:0] == duty_q;
   assign match_p = run && cnt_inc[9:0] == period_q;
   // pwm ignores clear-select; capture mode is not built and counts like pwm
   assign clear_cnt = (mode == MODE_COMPARE || mode == MODE_TIMER) && clear_select_q ?
                      match_a : match_p;
   assign raise_cmp = match_a;
   assign raise_per = match_p && !((mode == MODE_COMPARE || mode == MODE_TIMER) &&
                      clear_select_q);

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         enable_prev_q <= 1'b0;
      end else begin
         enable_prev_q <= counter_enable_q;
      end
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         cnt_q <= `PTM_RST_VAL10;
      end else if (enable_rise) begin
         cnt_q <= `PTM_RST_VAL10;
      end else if (run) begin
         cnt_q <= clear_cnt ? `PTM_RST_VAL10 : cnt_inc[9:0];
      end
   end

   // a new match wins over a software clear in the same cycle
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         cmp_flag_q <= 1'b0;
         per_flag_q <= 1'b0;
      end else begin
         cmp_flag_q <= raise_cmp || (cmp_flag_q && !(wr_flags && wdata_q[`PTM_FLAG_CMP]));
         per_flag_q <= raise_per || (per_flag_q && !(wr_flags && wdata_q[`PTM_FLAG_PER]));
      end
   end

   assign compare_req_o = cmp_flag_q;
   assign period_req_o = per_flag_q;

   ////////////////////////////////////////////////////////////////////////////////////////////
   // output pin

   logic pwm_active;
   logic pwm_level;
   logic pin_level;

   // duty at or above a nonzero period always exceeds cnt, so the pin stays active
   assign pwm_active = cnt_q < duty_q;

   always_comb begin
      case (action_q)
         `PTM_ACT_HOLD: pwm_level = !init_level_q;
         `PTM_ACT_LOW: pwm_level = init_level_q;
         `PTM_ACT_HIGH: pwm_level = pwm_active ? init_level_q : !init_level_q;
         default: pwm_level = !init_level_q; // single pulse is not built
      endcase
   end

   // compare-mode pin state: loaded on enable rise, otherwise only duty matches move it
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         pin_q <= 1'b0;
      end else if (enable_rise) begin
         pin_q <= init_level_q;
      end else if (match_a && mode == MODE_COMPARE) begin
         case (action_q)
            `PTM_ACT_LOW: pin_q <= 1'b0;
            `PTM_ACT_HIGH: pin_q <= 1'b1;
            `PTM_ACT_TOGGLE: pin_q <= !pin_q;
            default: pin_q <= pin_q;
         endcase
      end
   end

   assign pin_level = (mode == MODE_PWM ? pwm_level : pin_q) ^ invert_q;

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         timer_out_o <= 1'b0;
         timer_out_en_o <= 1'b0;
      end else begin
         timer_out_o <= pin_level;
         timer_out_en_o <= mode == MODE_COMPARE || mode == MODE_PWM;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////////////////
   // checks

   chk_enable_clears: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      enable_rise |=> cnt_q == 10'h000)
      else $error("counter not zero after enable rise");

   chk_pause_holds: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      (counter_pause_q && !enable_rise) |=> $stable(cnt_q))
      else $error("counter moved while paused");

   chk_pwm_period_wrap: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      (mode == MODE_PWM && match_p) |=> cnt_q == 10'h000 && per_flag_q)
      else $error("pwm period match did not clear counter");

   chk_flag_sticky: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      (cmp_flag_q && !wr_flags) |=> cmp_flag_q)
      else $error("compare flag dropped without clear");

   chk_no_period_flag: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      (mode == MODE_COMPARE && clear_select_q && !per_flag_q && !wr_ctrl1) |=> !per_flag_q)
      else $error("period flag raised with duty clear selected");

   chk_initial_level: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      enable_rise |=> pin_q == $past(init_level_q))
      else $error("pin not loaded with initial level");

   chk_pin_steady: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      (!match_a && !enable_rise) |=> $stable(pin_q))
      else $error("pin moved without duty match");

   chk_toggle_flip: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      (mode == MODE_COMPARE && match_a && action_q == `PTM_ACT_TOGGLE) |=>
      pin_q != $past(pin_q))
      else $error("toggle action did not flip pin");

   // follows the decode through to the registered pin, not just the comparator
   chk_full_duty: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      (mode == MODE_PWM && action_q == `PTM_ACT_HIGH && period_q != 10'h000 &&
      duty_q >= period_q && cnt_q < period_q) |=>
      timer_out_o == ($past(init_level_q) ^ $past(invert_q)))
      else $error("full duty not held active");

   chk_timer_undriven: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      (mode == MODE_TIMER) [*2] |-> !timer_out_en_o)
      else $error("timer mode drives the pin");

   cov_pwm_period: cover property (@(posedge clk_i) disable iff (!rst_n_i)
      mode == MODE_PWM && match_p);
   cov_compare_toggle: cover property (@(posedge clk_i) disable iff (!rst_n_i)
      mode == MODE_COMPARE && match_a && action_q == `PTM_ACT_TOGGLE);
   cov_pause: cover property (@(posedge clk_i) disable iff (!rst_n_i)
      counter_enable_q && counter_pause_q ##1 !counter_pause_q);
   cov_flag_clear: cover property (@(posedge clk_i) disable iff (!rst_n_i)
      cmp_flag_q && wr_flags ##1 !cmp_flag_q);

endmodule
